// File: hdl/efj_consts.vh
// Constants for the EEPROM fetch, flag refresh and jump execution unit
// Functional notes
// - Fetch loads accumulator from EEPROM, six cycles
// - Fetch holds one stack entry until done
// - Flag refresh sets sign and nonzero flags
// - Flag refresh keeps accumulator, one cycle
// - Jump loads PC; relative 3, absolute 4
// - Bit-clear jump taken when bit zero
// - Bit-set jump taken when bit one
`ifndef EFJ_CONSTS_VH
`define EFJ_CONSTS_VH
// Operation codes from the sequencer
`define EFJ_OP_FETCH     3'h1
`define EFJ_OP_FLAG      3'h2
`define EFJ_OP_JUMP      3'h3
`define EFJ_OP_BITC      3'h4
`define EFJ_OP_BITS      3'h5
// Cycle counts per instruction
`define EFJ_CYC_FETCH    3'h6
`define EFJ_CYC_FLAG     3'h1
`define EFJ_CYC_JREL     3'h3
`define EFJ_CYC_JABS     3'h4
`define EFJ_CYC_BIT      3'h4
// Instruction lengths in bytes
`define EFJ_LEN_JREL     16'h0002
`define EFJ_LEN_JABS     16'h0003
`define EFJ_LEN_BIT      16'h0003
// Cycle, counted from 1, in which the EEPROM read is issued
`define EFJ_FETCH_RD_CYC 3'h2
`endif

// File: hdl/efj_exec.v
// Execution unit for EEPROM fetch, flag refresh and jump instructions
`timescale 1ns/1ps
`include "efj_consts.vh"
module efj_exec #(
	parameter DW = 24,
	parameter AW = 16,
	parameter EW = 6
) (
	// Clock and reset
	input  wire          i_mclk,
	input  wire          i_nrst,
	// Sequencer request
	input  wire          i_start,
	input  wire [2:0]    i_op,
	input  wire [1:0]    i_acc_sel,
	input  wire [4:0]    i_bit_idx,
	input  wire          i_abs,
	input  wire [AW-1:0] i_pc,
	input  wire [AW-1:0] i_branch_target_label,
	// Accumulator file and RAM address pointer
	input  wire [DW-1:0] i_acc_x,
	input  wire [DW-1:0] i_acc_y,
	input  wire [DW-1:0] i_acc_z,
	input  wire [DW-1:0] i_acc_r,
	input  wire [EW-1:0] i_ram_ptr,
	// EEPROM read data, valid while the read strobe stands
	input  wire [DW-1:0] i_epr_data,
	// Sequencer answer
	output reg           o_busy,
	output reg           o_done,
	// Accumulator write port
	output reg           o_acc_we,
	output reg  [1:0]    o_acc_wsel,
	output reg  [DW-1:0] o_acc_wdata,
	// Flags
	output reg           o_flag_we,
	output reg           o_sign,
	output reg           o_nonzero,
	// Program counter load
	output reg           o_pc_we,
	output reg  [AW-1:0] o_pc_wdata,
	// Program counter stack
	output reg           o_stk_push,
	output reg           o_stk_pop,
	// EEPROM read port
	output reg           o_epr_rd,
	output reg  [EW-1:0] o_epr_addr
);
	localparam S_IDLE = 3'b001;
	localparam S_RUN  = 3'b010;
	localparam S_DONE = 3'b100;

	reg          rst_meta_reg;
	reg          rst_sync_reg;
	reg [2:0]    state_reg;
	reg [2:0]    op_reg;
	reg [1:0]    sel_reg;
	reg [4:0]    bit_reg;
	reg          abs_reg;
	reg [AW-1:0] pc_reg;
	reg [AW-1:0] tgt_reg;
	reg [2:0]    cyc_reg;
	reg [2:0]    len_reg;

	// Accumulator chosen by a two-bit selector
	function [DW-1:0] acc_pick;
		input [1:0] sel;
		begin
			case (sel)
			2'h0: acc_pick = i_acc_x;
			2'h1: acc_pick = i_acc_y;
			2'h2: acc_pick = i_acc_z;
			default: acc_pick = i_acc_r;
			endcase
		end
	endfunction

	// Total cycles of an operation
	function [2:0] op_len;
		input [2:0] op;
		input       ab;
		begin
			case (op)
			`EFJ_OP_FETCH: op_len = `EFJ_CYC_FETCH;
			`EFJ_OP_FLAG:  op_len = `EFJ_CYC_FLAG;
			`EFJ_OP_JUMP:  op_len = ab ? `EFJ_CYC_JABS : `EFJ_CYC_JREL;
			default:       op_len = `EFJ_CYC_BIT;
			endcase
		end
	endfunction

	wire [DW-1:0] acc_val = acc_pick(sel_reg);
	wire          bit_val = acc_val[bit_reg];
	wire [DW-1:0] new_acc = acc_pick(i_acc_sel);

	// Reset release through two flip-flops
	always @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Sequencing and result outputs
	always @(posedge i_mclk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			state_reg   <= S_IDLE;
			op_reg      <= 3'h0;
			sel_reg     <= 2'h0;
			bit_reg     <= 5'h00;
			abs_reg     <= 1'b0;
			pc_reg      <= {AW{1'b0}};
			tgt_reg     <= {AW{1'b0}};
			cyc_reg     <= 3'h0;
			len_reg     <= 3'h0;
			o_busy      <= 1'b0;
			o_done      <= 1'b0;
			o_acc_we    <= 1'b0;
			o_acc_wsel  <= 2'h0;
			o_acc_wdata <= {DW{1'b0}};
			o_flag_we   <= 1'b0;
			o_sign      <= 1'b0;
			o_nonzero   <= 1'b0;
			o_pc_we     <= 1'b0;
			o_pc_wdata  <= {AW{1'b0}};
			o_stk_push  <= 1'b0;
			o_stk_pop   <= 1'b0;
			o_epr_rd    <= 1'b0;
			o_epr_addr  <= {EW{1'b0}};
		end else begin
			o_done     <= 1'b0;
			o_acc_we   <= 1'b0;
			o_flag_we  <= 1'b0;
			o_pc_we    <= 1'b0;
			o_stk_push <= 1'b0;
			o_stk_pop  <= 1'b0;
			o_epr_rd   <= 1'b0;
			case (state_reg)
			S_IDLE: begin
				if (i_start) begin
					op_reg  <= i_op;
					sel_reg <= i_acc_sel;
					bit_reg <= i_bit_idx;
					abs_reg <= i_abs;
					pc_reg  <= i_pc;
					tgt_reg <= i_branch_target_label;
					len_reg <= op_len(i_op, i_abs);
					cyc_reg <= 3'h1;
					o_busy  <= 1'b1;
					if (i_op == `EFJ_OP_FLAG) begin
						// Flags from accumulator, no write back
						o_sign    <= new_acc[DW-1];
						o_nonzero <= |new_acc;
						o_flag_we <= 1'b1;
						o_done    <= 1'b1;
						o_busy    <= 1'b0;
					end else begin
						state_reg <= S_RUN;
						if (i_op == `EFJ_OP_FETCH) begin
							o_stk_push <= 1'b1;
						end
					end
				end
			end
			S_RUN: begin
				cyc_reg <= cyc_reg + 3'h1;
				if (op_reg == `EFJ_OP_FETCH &&
				    cyc_reg == `EFJ_FETCH_RD_CYC) begin
					o_epr_rd   <= 1'b1;
					o_epr_addr <= i_ram_ptr;
				end
				if (op_reg == `EFJ_OP_FETCH &&
				    cyc_reg == `EFJ_FETCH_RD_CYC + 3'h1) begin
					o_acc_wdata <= i_epr_data;
					o_acc_wsel  <= sel_reg;
				end
				// Request edge is cycle one and DONE is the last cycle, so
				// leave RUN two counts short of the length; one short would
				// stretch every multi-cycle instruction by a cycle
				if (cyc_reg + 3'h2 == len_reg) begin
					state_reg <= S_DONE;
				end
			end
			S_DONE: begin
				// Last cycle: commit the result
				state_reg <= S_IDLE;
				o_busy    <= 1'b0;
				o_done    <= 1'b1;
				case (op_reg)
				`EFJ_OP_FETCH: begin
					o_acc_we  <= 1'b1;
					o_stk_pop <= 1'b1;
				end
				`EFJ_OP_JUMP: begin
					o_pc_we    <= 1'b1;
					o_pc_wdata <= tgt_reg;
				end
				`EFJ_OP_BITC, `EFJ_OP_BITS: begin
					o_pc_we <= 1'b1;
					if ((op_reg == `EFJ_OP_BITC && !bit_val) ||
					    (op_reg == `EFJ_OP_BITS && bit_val)) begin
						o_pc_wdata <= tgt_reg;
					end else begin
						o_pc_wdata <= pc_reg + `EFJ_LEN_BIT;
					end
				end
				default: begin
					o_pc_we <= 1'b0;
				end
				endcase
			end
			default: begin
				state_reg <= S_IDLE;
				o_busy    <= 1'b0;
			end
			endcase
		end
	end
endmodule // efj_exec

// File: testbench/efj_epr_model.sv
// Behavioural EEPROM that answers the read strobe
`timescale 1ns/1ps
module efj_epr_model (
	input  wire        i_mclk,
	input  wire        i_rd,
	input  wire [5:0]  i_addr,
	output wire [23:0] o_data
);
	reg [23:0] junk_reg = 24'h5A_5A5A;
	// Scrambled word between reads, so a capture off the strobe shows up
	always @(posedge i_mclk) junk_reg <= ~junk_reg;
	// Word stands while the strobe does; the unit captures it then
	assign o_data = i_rd ? {4{i_addr}} : junk_reg;
endmodule // efj_epr_model

// File: testbench/efj_exec_chk.sv
// Timing checker for the execution unit
`timescale 1ns/1ps
`include "efj_consts.vh"
module efj_exec_chk (
	input wire       i_mclk, i_nrst, i_start, i_abs, o_busy, o_done,
	input wire       o_acc_we, o_flag_we, o_pc_we, o_stk_push, o_stk_pop,
	input wire [2:0] i_op
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	// Request taken while idle, split by kind
	wire go = i_start && !o_busy;
	wire fe = go && i_op == `EFJ_OP_FETCH;
	wire fl = go && i_op == `EFJ_OP_FLAG;
	wire jp = go && i_op == `EFJ_OP_JUMP;
	wire bc = go && i_op == `EFJ_OP_BITC;
	wire bs = go && i_op == `EFJ_OP_BITS;
	wire bj = bc || bs;
	fetch_len_a: assert property (fe |-> ##6 o_done)
		else $error("fetch length");
	fetch_we_a: assert property (fe |-> ##6 o_acc_we)
		else $error("fetch write");
	fetch_stk_a: assert property (fe |=> o_stk_push ##5 o_stk_pop)
		else $error("stack hold");
	flag_one_a: assert property (fl |=> o_flag_we && o_done)
		else $error("flag length");
	flag_keep_a: assert property (fl |=> !o_acc_we)
		else $error("flag wrote acc");
	jrel_len_a: assert property (jp && !i_abs |-> ##3 o_pc_we && o_done)
		else $error("rel jump length");
	jabs_len_a: assert property (jp && i_abs |-> ##4 o_pc_we && o_done)
		else $error("abs jump length");
	bitc_len_a: assert property (bc |-> ##4 o_pc_we)
		else $error("bit clear length");
	bits_len_a: assert property (bs |-> ##4 o_pc_we)
		else $error("bit set length");
	bit_quiet_a: assert property (bj |=> (!o_acc_we && !o_flag_we) [*4])
		else $error("bit jump side effect");
	cover property (fe);
	cover property (fl);
	cover property (jp && i_abs);
	cover property (bj);
endmodule // efj_exec_chk
bind efj_exec efj_exec_chk chk (.i_mclk, .i_nrst, .i_start, .i_abs, .o_busy,
	.o_done, .o_acc_we, .o_flag_we, .o_pc_we, .o_stk_push, .o_stk_pop, .i_op);

// File: testbench/efj_exec_bench.sv
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin error_cnt++; \
	$display("Error %s exp %h got %h", n, e, s); end end
module efj_exec_bench;
	logic i_mclk = 0, i_nrst = 0, i_start = 0, i_abs = 0;
	logic [2:0] i_op = 0;
	logic [1:0] i_acc_sel = 0;
	logic [4:0] i_bit_idx = 0;
	logic [15:0] i_pc = 16'h0100, i_branch_target_label = 16'h0400;
	logic [23:0] i_acc_x = 24'h80_0000, i_acc_y = 0;
	logic [23:0] i_acc_z = 24'h00_0005, i_acc_r = 24'h7F_FFFF;
	logic [5:0] i_ram_ptr = 6'h2A;
	wire o_busy, o_done, o_acc_we, o_flag_we, o_sign, o_nonzero, o_pc_we, rd;
	wire o_stk_push;
	wire [23:0] o_acc_wdata, epr;
	wire [15:0] o_pc_wdata;
	wire [5:0] ad;
	wire [1:0] ws;
	int error_cnt = 0, num_checks = 0, cyc = 0, k;
	// Rows: op, acc, bit, abs, cycles, expected result
	logic [29:0] rows [11] = '{30'h0806_AAAA, 30'h1001_0003, 30'h1201_0000,
		30'h1601_0001, 30'h1803_0400, 30'h180C_0400, 30'h2374_0400,
		30'h2174_0103, 30'h2974_0400, 30'h2C14_0103, 30'h2C04_0400};
	always #5 i_mclk = ~i_mclk;
	efj_exec uut (.i_mclk, .i_nrst, .i_start, .i_op, .i_acc_sel, .i_bit_idx,
		.i_abs, .i_pc, .i_branch_target_label, .i_acc_x, .i_acc_y, .i_acc_z,
		.i_acc_r, .i_ram_ptr, .i_epr_data(epr), .o_busy, .o_done, .o_acc_we,
		.o_acc_wsel(ws), .o_acc_wdata, .o_flag_we, .o_sign, .o_nonzero, .o_pc_we,
		.o_pc_wdata, .o_stk_push, .o_stk_pop(), .o_epr_rd(rd), .o_epr_addr(ad));
	efj_epr_model mem (.i_mclk, .i_rd(rd), .i_addr(ad), .o_data(epr));
	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// One request, then wait for done under a bound
	task automatic run(input logic [29:0] r);
		@(negedge i_mclk);
		{i_op, i_acc_sel, i_bit_idx, i_abs} = r[29:19];
		i_start = 1;
		@(negedge i_mclk);
		i_start = 0;
		k = 1;
		while (o_done !== 1'b1 && k < 20) begin
			@(negedge i_mclk);
			k++;
		end
		`CHK("cycles", {2'h0, r[18:16]}, k[4:0])
		`CHK("result", r[15:0], i_op == 1 ? o_acc_wdata[15:0] : i_op == 2 ?
			{14'h0, o_sign, o_nonzero} : o_pc_wdata)
	endtask
	// Cycle ceiling
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			report_and_stop;
		end
	end
	initial begin
		repeat (20) @(negedge i_mclk);
		i_nrst = 1;
		repeat (3) @(negedge i_mclk);
		`CHK("idle", 2'h0, {o_busy, o_stk_push})
		foreach (rows[i]) run(rows[i]);
		// Flag request held high during a fetch, taken after it
		@(negedge i_mclk);
		{i_op, i_acc_sel, i_start} = 6'h0B;
		@(negedge i_mclk);
		{i_op, i_acc_sel} = 5'h08;
		k = 0;
		repeat (5) begin
			@(negedge i_mclk);
			k += o_flag_we;
		end
		`CHK("refused", 0, k)
		@(negedge i_mclk);
		`CHK("fetch", 25'h1AA_AAAA, {o_done, o_acc_wdata})
		`CHK("wsel", 2'h1, ws)
		`CHK("flag", 3'h7, {o_flag_we, o_sign, o_nonzero})
		i_start = 0;
		// Reset in mid-fetch drops the operation and its stack hold
		repeat (2) @(negedge i_mclk);
		{i_op, i_start} = 4'h3;
		@(negedge i_mclk);
		i_start = 0;
		repeat (2) @(negedge i_mclk);
		`CHK("busy", 1'b1, o_busy)
		i_nrst = 0;
		@(negedge i_mclk);
		`CHK("reset", 3'h0, {o_busy, o_done, o_stk_push})
		i_nrst = 1;
		repeat (3) @(negedge i_mclk);
		run(rows[0]);
		report_and_stop;
	end
endmodule // efj_exec_bench
